// ==== src/cfa_pkg.sv ====
package cfa_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_INDEX = 8'h04;
    localparam logic [7:0] ADDR_STACK = 8'h08;
    localparam logic [7:0] ADDR_PROGCNT = 8'h0C;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    localparam logic [7:0] ADDR_RESULT = 8'h18;

    // ----------------------------------------------------------------
    // Flag bit positions in flags_byte
    // ----------------------------------------------------------------
    localparam int FLAG_WRAP = 7;
    localparam int FLAG_NIBBLE = 4;
    localparam int FLAG_MASK = 3;
    localparam int FLAG_MSB = 2;
    localparam int FLAG_NULL = 1;
    localparam int FLAG_BORROW = 0;
    localparam logic [7:0] FLAGS_USED = 8'h9F;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int DATA_ACC_LSB = 0;
    localparam int DATA_OPND_LSB = 8;
    localparam int DATA_WORD_LSB = 16;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_MODE_LSB = 8;
    localparam int RES_BRANCH_BIT = 16;
    localparam int RES_BUSY_BIT = 17;
    localparam int RES_INHIBIT_BIT = 18;
    localparam int RES_ACC_LSB = 24;

    // ----------------------------------------------------------------
    // Reset values and constants
    // ----------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET = 8'h08;
    localparam logic [15:0] STACK_RESET = 16'h00FF;
    localparam logic [15:0] INDEX_RESET = 16'h0000;
    localparam logic [15:0] PROGCNT_RESET = 16'h0000;
    localparam logic [15:0] INDEX_STEP = 16'h0001;
    localparam logic [2:0] PUSH_LAST = 3'h4;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
    localparam logic [3:0] BCD_FIX = 4'h6;

    // ----------------------------------------------------------------
    // Operations, addressing modes, interrupt sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NONE = 5'h00, OP_SUM = 5'h01, OP_SUM_CARRY = 5'h02, OP_DIFF = 5'h03,
        OP_DIFF_BORROW = 5'h04, OP_DECIMAL_ADJUST = 5'h05, OP_AND = 5'h06,
        OP_LOAD = 5'h07, OP_STORE = 5'h08, OP_LOAD_INDEX = 5'h09,
        OP_SHIFT_LEFT = 5'h0A, OP_ROTATE_RIGHT = 5'h0B, OP_BIT_TEST = 5'h0C,
        OP_CLEAR_MASK = 5'h0D, OP_ACCUM_TO_FLAGS = 5'h0E, OP_SET_MASK = 5'h0F,
        OP_BRANCH_GREATER = 5'h10, OP_BRANCH_GREATER_EQUAL = 5'h11,
        OP_BRANCH_LESS_EQUAL = 5'h12, OP_BRANCH_LESS = 5'h13,
        OP_COMPARE_BRANCH_EQUAL = 5'h14, OP_MEMORY_TRANSFER = 5'h15
    } cfa_op_t;

    typedef enum logic [2:0] {
        MODE_FULL_ADDR = 3'h0, MODE_INDEX_PLAIN = 3'h1, MODE_INDEX_POSTINC = 3'h2,
        MODE_INDEX_SHORT_OFFSET = 3'h3, MODE_INDEX_SHORT_OFFSET_POSTINC = 3'h4,
        MODE_INDEX_LONG_OFFSET = 3'h5, MODE_STACK_SHORT_OFFSET = 3'h6,
        MODE_STACK_LONG_OFFSET = 3'h7
    } cfa_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_PUSH = 2'b01, ST_MASK = 2'b10
    } cfa_state_t;

endpackage : cfa_pkg

// ==== src/cfa_core.sv ====
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module cfa_core (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt request and stack push port
    input wire logic irqReq,
    output logic stackWrStb,
    output logic [15:0] stackWrAddr,
    output logic [7:0] stackWrData,
    output logic intAck
);
    import cfa_pkg::*;

    // ----------------------------------------------------------------
    // Reset and input synchronisers
    // ----------------------------------------------------------------
    logic rstMeta_q, rstSync_q, irqMeta_q, irqSync_q;
    wire logic rstN = rstSync_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            irqMeta_q <= 1'b0;
            irqSync_q <= 1'b0;
        end else begin
            irqMeta_q <= irqReq;
            irqSync_q <= irqMeta_q;
        end
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    logic [7:0] flags_q, flags_d, acc_q, acc_d, opnd_q;
    logic [15:0] index_q, index_d, stack_q, pc_q, word_q, ea_q;
    logic [4:0] cmdOp_q;
    logic [2:0] cmdMode_q, pushCnt_q;
    logic exec_q, bound_q, branch_q, inhibit_q, inhibit_d, branch_d;
    cfa_state_t state_q;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire logic busy = (state_q != ST_IDLE);
    wire logic selFlags = (paddr == ADDR_FLAGS);
    wire logic selIndex = (paddr == ADDR_INDEX);
    wire logic selStack = (paddr == ADDR_STACK);
    wire logic selPc = (paddr == ADDR_PROGCNT);
    wire logic selData = (paddr == ADDR_DATA);
    wire logic selCmd = (paddr == ADDR_CMD);
    wire logic selResult = (paddr == ADDR_RESULT);
    wire logic mapped = selFlags | selIndex | selStack | selPc | selData | selCmd | selResult;
    wire logic [31:0] resultWord = {acc_q, 5'h00, inhibit_q, busy, branch_q, ea_q};
    wire logic [31:0] rdWord = selFlags ? {24'h00_0000, flags_q} :
                               selIndex ? {16'h0000, index_q} :
                               selStack ? {16'h0000, stack_q} :
                               selPc ? {16'h0000, pc_q} :
                               selData ? {word_q, opnd_q, acc_q} :
                               selCmd ? {21'h00_0000, cmdMode_q, 3'h0, cmdOp_q} :
                               selResult ? resultWord : 32'h0000_0000;
    wire logic [31:0] strbMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire logic [31:0] wrVal = (rdWord & ~strbMask) | (pwdata & strbMask);
    wire logic apbFirst = psel & penable & ~pready;
    wire logic errD = ~mapped | (pwrite & (selResult | busy));
    // A write is dropped if an interrupt sequence began after it was checked
    wire logic commitWr = psel & penable & pready & pwrite & ~pslverr & ~busy;
    wire logic wrFlags = commitWr & selFlags;
    wire logic wrIndex = commitWr & selIndex;
    wire logic wrStack = commitWr & selStack;
    wire logic wrPc = commitWr & selPc;
    wire logic wrData = commitWr & selData;
    wire logic wrCmd = commitWr & selCmd;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apbFirst;
            pslverr <= apbFirst & errD;
            prdata <= (apbFirst & ~pwrite) ? rdWord : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Effective address
    // ----------------------------------------------------------------
    wire cfa_mode_t mode = cfa_mode_t'(cmdMode_q);
    wire cfa_op_t op = cfa_op_t'(cmdOp_q);
    wire logic [15:0] off8 = {8'h00, word_q[7:0]};
    wire logic [15:0] idxShort = index_q + off8;
    wire logic [15:0] idxLong = index_q + word_q;
    wire logic [15:0] spShort = stack_q + off8;
    wire logic [15:0] spLong = stack_q + word_q;
    wire logic [15:0] eaD =
        (mode == MODE_FULL_ADDR) ? {word_q[15:8], word_q[7:0]} :
        (mode == MODE_INDEX_PLAIN || mode == MODE_INDEX_POSTINC) ? index_q :
        (mode == MODE_INDEX_SHORT_OFFSET || mode == MODE_INDEX_SHORT_OFFSET_POSTINC) ? idxShort :
        (mode == MODE_INDEX_LONG_OFFSET) ? idxLong :
        (mode == MODE_STACK_SHORT_OFFSET) ? spShort :
        spLong;
    wire logic postInc =
        (op == OP_COMPARE_BRANCH_EQUAL &&
         (mode == MODE_INDEX_POSTINC || mode == MODE_INDEX_SHORT_OFFSET_POSTINC)) ||
        (op == OP_MEMORY_TRANSFER && mode == MODE_INDEX_POSTINC);
    wire logic [15:0] indexInc = index_q + INDEX_STEP;

    // ----------------------------------------------------------------
    // Flag and result logic
    // ----------------------------------------------------------------
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [15:0] nzVal;
    logic nzUpd, nzWide, cin, lowFix, highFix, loadIndex, signLess;

    always_comb begin
        flags_d = flags_q;
        acc_d = acc_q;
        branch_d = 1'b0;
        inhibit_d = 1'b0;
        loadIndex = 1'b0;
        nzUpd = 1'b0;
        nzWide = 1'b0;
        nzVal = {8'h00, acc_q};
        sum9 = 9'h000;
        nib5 = 5'h00;
        cin = flags_q[FLAG_BORROW];
        lowFix = 1'b0;
        highFix = 1'b0;
        signLess = flags_q[FLAG_MSB] ^ flags_q[FLAG_WRAP];
        case (op)
            OP_SUM, OP_SUM_CARRY: begin
                if (op == OP_SUM) cin = 1'b0;
                sum9 = {1'b0, acc_q} + {1'b0, opnd_q} + {8'h00, cin};
                nib5 = {1'b0, acc_q[3:0]} + {1'b0, opnd_q[3:0]} + {4'h0, cin};
                acc_d = sum9[7:0];
                flags_d[FLAG_NIBBLE] = nib5[4];
                flags_d[FLAG_BORROW] = sum9[8];
                flags_d[FLAG_WRAP] = (acc_q[7] == opnd_q[7]) && (sum9[7] != acc_q[7]);
                nzUpd = 1'b1;
                nzVal = {8'h00, sum9[7:0]};
            end
            OP_DIFF, OP_DIFF_BORROW: begin
                if (op == OP_DIFF) cin = 1'b0;
                sum9 = {1'b0, acc_q} - {1'b0, opnd_q} - {8'h00, cin};
                acc_d = sum9[7:0];
                flags_d[FLAG_BORROW] = sum9[8];
                flags_d[FLAG_WRAP] = (acc_q[7] != opnd_q[7]) && (sum9[7] != acc_q[7]);
                nzUpd = 1'b1;
                nzVal = {8'h00, sum9[7:0]};
            end
            OP_DECIMAL_ADJUST: begin
                lowFix = flags_q[FLAG_NIBBLE] || (acc_q[3:0] > BCD_DIGIT_MAX);
                highFix = flags_q[FLAG_BORROW] || (acc_q > BCD_BYTE_MAX);
                acc_d = acc_q + {(highFix ? BCD_FIX : 4'h0), (lowFix ? BCD_FIX : 4'h0)};
                flags_d[FLAG_BORROW] = highFix;
                nzUpd = 1'b1;
                nzVal = {8'h00, acc_d};
            end
            OP_AND: begin
                acc_d = acc_q & opnd_q;
                flags_d[FLAG_WRAP] = 1'b0;
                nzUpd = 1'b1;
                nzVal = {8'h00, acc_d};
            end
            OP_LOAD, OP_MEMORY_TRANSFER: begin
                if (op == OP_LOAD) acc_d = opnd_q;
                flags_d[FLAG_WRAP] = 1'b0;
                nzUpd = 1'b1;
                nzVal = {8'h00, opnd_q};
            end
            OP_STORE: begin
                flags_d[FLAG_WRAP] = 1'b0;
                nzUpd = 1'b1;
            end
            OP_LOAD_INDEX: begin
                loadIndex = 1'b1;
                flags_d[FLAG_WRAP] = 1'b0;
                nzUpd = 1'b1;
                nzWide = 1'b1;
                nzVal = word_q;
            end
            OP_SHIFT_LEFT: begin
                acc_d = {acc_q[6:0], 1'b0};
                flags_d[FLAG_BORROW] = acc_q[7];
                flags_d[FLAG_WRAP] = acc_q[6] ^ acc_q[7];
                nzUpd = 1'b1;
                nzVal = {8'h00, acc_d};
            end
            OP_ROTATE_RIGHT: begin
                acc_d = {flags_q[FLAG_BORROW], acc_q[7:1]};
                flags_d[FLAG_BORROW] = acc_q[0];
                flags_d[FLAG_WRAP] = flags_q[FLAG_BORROW] ^ acc_q[0];
                nzUpd = 1'b1;
                nzVal = {8'h00, acc_d};
            end
            OP_BIT_TEST: begin
                flags_d[FLAG_BORROW] = opnd_q[word_q[2:0]];
                branch_d = opnd_q[word_q[2:0]];
            end
            OP_CLEAR_MASK: begin
                flags_d[FLAG_MASK] = 1'b0;
                inhibit_d = flags_q[FLAG_MASK];
            end
            OP_ACCUM_TO_FLAGS: begin
                flags_d = acc_q & FLAGS_USED;
                inhibit_d = flags_q[FLAG_MASK] & ~acc_q[FLAG_MASK];
            end
            OP_SET_MASK: flags_d[FLAG_MASK] = 1'b1;
            OP_BRANCH_GREATER: branch_d = ~(flags_q[FLAG_NULL] | signLess);
            OP_BRANCH_GREATER_EQUAL: branch_d = ~signLess;
            OP_BRANCH_LESS_EQUAL: branch_d = flags_q[FLAG_NULL] | signLess;
            OP_BRANCH_LESS: branch_d = signLess;
            OP_COMPARE_BRANCH_EQUAL: branch_d = (acc_q == opnd_q);
            default: begin
                flags_d = flags_q;
            end
        endcase
        if (nzUpd) begin
            flags_d[FLAG_MSB] = nzWide ? nzVal[15] : nzVal[7];
            flags_d[FLAG_NULL] = nzWide ? (nzVal == 16'h0000) : (nzVal[7:0] == 8'h00);
        end
    end

    assign index_d = loadIndex ? word_q : (postInc ? indexInc : index_q);

    // ----------------------------------------------------------------
    // Command and execute pipeline
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            cmdOp_q <= OP_NONE;
            cmdMode_q <= MODE_FULL_ADDR;
            exec_q <= 1'b0;
            bound_q <= 1'b0;
            branch_q <= 1'b0;
            ea_q <= 16'h0000;
        end else begin
            exec_q <= wrCmd;
            bound_q <= exec_q;
            if (wrCmd) begin
                cmdOp_q <= wrVal[CMD_OP_LSB +: 5];
                cmdMode_q <= wrVal[CMD_MODE_LSB +: 3];
            end
            if (exec_q) begin
                branch_q <= branch_d;
                ea_q <= eaD;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt sequencer
    // ----------------------------------------------------------------
    // acceptance at a boundary
    wire logic accept = bound_q & irqSync_q & ~flags_q[FLAG_MASK] & ~inhibit_q & ~busy;
    wire logic [7:0] pushByte = (pushCnt_q == 3'h0) ? pc_q[7:0] :
                                (pushCnt_q == 3'h1) ? pc_q[15:8] :
                                (pushCnt_q == 3'h2) ? index_q[7:0] :
                                (pushCnt_q == 3'h3) ? acc_q : flags_q;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            state_q <= ST_IDLE;
            pushCnt_q <= 3'h0;
            stackWrStb <= 1'b0;
            stackWrAddr <= 16'h0000;
            stackWrData <= 8'h00;
            intAck <= 1'b0;
        end else begin
            stackWrStb <= (state_q == ST_PUSH);
            stackWrAddr <= stack_q;
            stackWrData <= pushByte;
            intAck <= (state_q == ST_MASK);
            case (state_q)
                ST_IDLE: begin
                    pushCnt_q <= 3'h0;
                    if (accept) state_q <= ST_PUSH;
                end
                ST_PUSH: begin
                    pushCnt_q <= pushCnt_q + 3'h1;
                    if (pushCnt_q == PUSH_LAST) state_q <= ST_MASK;
                end
                ST_MASK: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Architectural registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            flags_q <= FLAGS_RESET;
            inhibit_q <= 1'b0;
        end else begin
            if (state_q == ST_MASK) flags_q[FLAG_MASK] <= 1'b1;
            else if (exec_q) flags_q <= flags_d;
            else if (wrFlags) flags_q <= wrVal[7:0] & FLAGS_USED;
            if (exec_q) inhibit_q <= inhibit_d;
            else if (bound_q) inhibit_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            index_q <= INDEX_RESET;
            stack_q <= STACK_RESET;
            pc_q <= PROGCNT_RESET;
            acc_q <= 8'h00;
            opnd_q <= 8'h00;
            word_q <= 16'h0000;
        end else begin
            if (exec_q) index_q <= index_d;
            else if (wrIndex) index_q <= wrVal[15:0];
            // Stack grows down, one byte per push
            if (state_q == ST_PUSH) stack_q <= stack_q - 16'h0001;
            else if (wrStack) stack_q <= wrVal[15:0];
            if (wrPc) pc_q <= wrVal[15:0];
            if (exec_q) acc_q <= acc_d;
            else if (wrData) acc_q <= wrVal[DATA_ACC_LSB +: 8];
            if (wrData) begin
                opnd_q <= wrVal[DATA_OPND_LSB +: 8];
                word_q <= wrVal[DATA_WORD_LSB +: 16];
            end
        end
    end

endmodule : cfa_core

`default_nettype wire

// ==== verif/cfa_core_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checks
// ----------------------------------------------------------------
module cfa_core_monitor
    import cfa_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Stack push
    input wire logic stackWrStb,
    input wire logic [15:0] stackWrAddr,
    input wire logic intAck
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access start");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    a_unmapped_err: assert property (pready && paddr > ADDR_RESULT |-> pslverr)
        else $error("no error on unmapped address");
    a_flags_spare: assert property (pready && !pwrite && paddr == ADDR_FLAGS
        |-> prdata[31:8] == 24'h00_0000 && prdata[6:5] == 2'b00) else $error("spare bits");
    a_push_five: assert property ($rose(stackWrStb) |-> stackWrStb[*5] ##1 !stackWrStb)
        else $error("push run not five bytes");
    a_push_step: assert property (stackWrStb && $past(stackWrStb)
        |-> stackWrAddr == $past(stackWrAddr) - 16'h0001) else $error("push address step");
    a_ack_follows: assert property ($fell(stackWrStb) |-> ##[0:2] intAck)
        else $error("no ack after push");
    a_ack_after_push: assert property (intAck |-> !stackWrStb &&
        ($past(stackWrStb) || $past(stackWrStb, 2))) else $error("ack without push");
    a_ack_pulse: assert property (intAck |=> !intAck) else $error("ack too long");
    cover property ($rose(stackWrStb));
    cover property (intAck);
    cover property (pready && pslverr);
endmodule : cfa_core_monitor
bind cfa_core cfa_core_monitor i_cfa_core_monitor (.mclk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .stackWrStb, .stackWrAddr, .intAck);
`default_nettype wire

// ==== verif/cfa_core_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfa_core_bench;
    import cfa_pkg::*;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, irqReq = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, stackWrStb, intAck, rerr;
    logic [15:0] stackWrAddr;
    logic [7:0] stackWrData;
    logic [23:0] pushed[$];
    int n_mismatch = 0, checks = 0, cyc = 0, nAck = 0;
    always #50 mclk = ~mclk;
    cfa_core i_cfa_core (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .irqReq, .stackWrStb, .stackWrAddr, .stackWrData, .intAck);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (stackWrStb === 1'b1) pushed.push_back({stackWrAddr, stackWrData});
        if (intAck === 1'b1) nAck <= nAck + 1;
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Setup waits an edge first so a release and the next setup never share a time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Only the cycle ceiling ends a wait that never gets its answer
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cmd(input cfa_op_t op, input cfa_mode_t m);
        apb(1'b1, ADDR_CMD, {21'h0, m, 3'h0, op});
        repeat (3) @(posedge mclk);
        apb(1'b0, ADDR_RESULT, 32'h0);
    endtask : cmd
    task automatic flg(input logic [7:0] msk, input logic [7:0] exp);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk("flags", {24'h0, exp}, {24'h0, rdata[7:0] & msk});
    endtask : flg
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        flg(8'hFF, FLAGS_RESET);
        apb(1'b0, ADDR_STACK, 32'h0);
        chk("stack", {16'h0, STACK_RESET}, rdata);
        pstrb <= 4'h2;
        apb(1'b1, ADDR_DATA, 32'hFFFF_FFFF);
        pstrb <= 4'hF;
        apb(1'b0, ADDR_DATA, 32'h0);
        chk("lane write", 32'h0000_FF00, rdata);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
    endtask : t_reset
    task automatic t_arith;
        apb(1'b1, ADDR_DATA, 32'h0000_017F);
        cmd(OP_SUM, MODE_FULL_ADDR);
        flg(8'hFF, 8'h9C);
        apb(1'b1, ADDR_DATA, 32'h0000_01FF);
        cmd(OP_SUM, MODE_FULL_ADDR);
        flg(8'hFF, 8'h1B);
        apb(1'b1, ADDR_DATA, 32'h0000_2819);
        cmd(OP_SUM, MODE_FULL_ADDR);
        cmd(OP_DECIMAL_ADJUST, MODE_FULL_ADDR);
        chk("decimal acc", 32'h47, {24'h0, rdata[31:24]});
        apb(1'b1, ADDR_DATA, 32'h0000_0201);
        cmd(OP_DIFF, MODE_FULL_ADDR);
        flg(8'h87, 8'h05);
        apb(1'b1, ADDR_DATA, 32'h0000_0055);
        cmd(OP_LOAD, MODE_FULL_ADDR);
        flg(8'h06, 8'h02);
        apb(1'b1, ADDR_DATA, 32'h0000_0081);
        cmd(OP_SHIFT_LEFT, MODE_FULL_ADDR);
        flg(8'h01, 8'h01);
        apb(1'b1, ADDR_FLAGS, 32'h0000_0088);
        cmd(OP_BRANCH_LESS, MODE_FULL_ADDR);
        chk("less taken", 32'h1, {31'h0, rdata[RES_BRANCH_BIT]});
        cmd(OP_BRANCH_GREATER_EQUAL, MODE_FULL_ADDR);
        chk("ge taken", 32'h0, {31'h0, rdata[RES_BRANCH_BIT]});
    endtask : t_arith
    task automatic t_modes;
        logic [15:0] ea [8] = '{16'h1020, 16'hFFF0, 16'hFFF0, 16'h0010,
            16'h0010, 16'h1010, 16'h1254, 16'h2254};
        apb(1'b1, ADDR_INDEX, 32'h0000_FFF0);
        apb(1'b1, ADDR_STACK, 32'h0000_1234);
        apb(1'b1, ADDR_DATA, 32'h1020_0000);
        for (int i = 0; i < 8; i++) begin
            cmd(OP_NONE, cfa_mode_t'(i));
            chk("address", {16'h0, ea[i]}, {16'h0, rdata[15:0]});
        end
        apb(1'b1, ADDR_INDEX, 32'h0000_FFFF);
        cmd(OP_COMPARE_BRANCH_EQUAL, MODE_INDEX_POSTINC);
        cmd(OP_MEMORY_TRANSFER, MODE_INDEX_SHORT_OFFSET_POSTINC);
        cmd(OP_COMPARE_BRANCH_EQUAL, MODE_INDEX_SHORT_OFFSET_POSTINC);
        chk("postinc addr", 32'h0020, {16'h0, rdata[15:0]});
        apb(1'b0, ADDR_INDEX, 32'h0);
        chk("index", 32'h0001, rdata);
    endtask : t_modes
    task automatic t_more;
        apb(1'b1, ADDR_FLAGS, 32'h0000_0001);
        apb(1'b1, ADDR_DATA, 32'h0000_0808);
        cmd(OP_SUM_CARRY, MODE_FULL_ADDR);
        flg(8'hFF, 8'h10);
        apb(1'b1, ADDR_FLAGS, 32'h0000_0001);
        apb(1'b1, ADDR_DATA, 32'h0000_0180);
        cmd(OP_DIFF_BORROW, MODE_FULL_ADDR);
        flg(8'hFF, 8'h80);
        cmd(OP_BRANCH_GREATER, MODE_FULL_ADDR);
        chk("gt taken", 32'h0, {31'h0, rdata[RES_BRANCH_BIT]});
        cmd(OP_BRANCH_LESS_EQUAL, MODE_FULL_ADDR);
        chk("le taken", 32'h1, {31'h0, rdata[RES_BRANCH_BIT]});
        apb(1'b1, ADDR_DATA, 32'h0000_0003);
        cmd(OP_ROTATE_RIGHT, MODE_FULL_ADDR);
        flg(8'h87, 8'h81);
        apb(1'b1, ADDR_DATA, 32'h0000_0200);
        cmd(OP_BIT_TEST, MODE_FULL_ADDR);
        flg(8'h01, 8'h00);
        apb(1'b1, ADDR_DATA, 32'h8000_0000);
        cmd(OP_LOAD_INDEX, MODE_FULL_ADDR);
        flg(8'h06, 8'h04);
        apb(1'b1, ADDR_DATA, 32'h0000_FF00);
        cmd(OP_STORE, MODE_FULL_ADDR);
        flg(8'h06, 8'h02);
    endtask : t_more
    task automatic t_irq;
        logic [7:0] exp [5] = '{8'hCD, 8'hAB, 8'h55, 8'h33, 8'h00};
        apb(1'b1, ADDR_PROGCNT, 32'h0000_ABCD);
        apb(1'b1, ADDR_INDEX, 32'h0000_0055);
        apb(1'b1, ADDR_STACK, 32'h0000_00FF);
        apb(1'b1, ADDR_DATA, 32'h0000_0033);
        apb(1'b1, ADDR_FLAGS, 32'h0000_0008);
        irqReq <= 1'b1;
        cmd(OP_NONE, MODE_FULL_ADDR);
        cmd(OP_CLEAR_MASK, MODE_FULL_ADDR);
        repeat (8) @(posedge mclk);
        chk("early push", 32'h0, 32'(pushed.size()));
        apb(1'b1, ADDR_CMD, 32'h0000_0000);
        repeat (12) @(posedge mclk);
        chk("push count", 32'h5, 32'(pushed.size()));
        chk("ack count", 32'h1, 32'(nAck));
        for (int i = 0; i < 5; i++) begin
            chk("pushed", {8'h0, 16'h00FF - 16'(i), exp[i]}, {8'h0, pushed[i]});
        end
        flg(8'h08, 8'h08);
        apb(1'b0, ADDR_STACK, 32'h0);
        chk("stack after", 32'h00FA, rdata);
        apb(1'b1, ADDR_DATA, 32'h0000_0000);
        cmd(OP_ACCUM_TO_FLAGS, MODE_FULL_ADDR);
        chk("flags copy hold", 32'h5, 32'(pushed.size()));
        irqReq <= 1'b0;
    endtask : t_irq
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_arith();
        t_modes();
        t_more();
        t_irq();
        tally_and_finish();
    end
endmodule : cfa_core_bench
`default_nettype wire
